// ===== hw/phy_status_regs.sv

`timescale 1ns/100ps
`default_nettype none

`include "phy_regs_params.svh"

module phy_status_regs
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic soft_reset,
    input wire phy_state_t line_state,
    input wire phy_pulse_t line_pulse,
    input wire mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    output logic event_pending,
    output logic mdix_select
);

    // ======================================================================
    // Access decode
    logic rd_ctrl;
    logic rd_status;
    logic rd_enable;
    logic rd_events;
    logic wr_ctrl;
    logic wr_enable;

    always_comb begin
        rd_ctrl = 1'b0;
        rd_status = 1'b0;
        rd_enable = 1'b0;
        rd_events = 1'b0;
        wr_ctrl = 1'b0;
        wr_enable = 1'b0;
        if (mgmt_req.addr == `ADDR_PHY_CTRL) begin
            rd_ctrl = mgmt_req.rd;
            wr_ctrl = mgmt_req.wr;
        end else if (mgmt_req.addr == `ADDR_LINK_STATUS) begin
            rd_status = mgmt_req.rd;
        end else if (mgmt_req.addr == `ADDR_EVENT_ENABLE) begin
            rd_enable = mgmt_req.rd;
            wr_enable = mgmt_req.wr;
        end else if (mgmt_req.addr == `ADDR_EVENT_STATUS) begin
            rd_events = mgmt_req.rd;
        end
    end

    // ======================================================================
    // Control register and the active crossover mode
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    xover_sel_t xmode_reg;
    xover_sel_t xmode_next;
    logic [1:0] mode_field;

    assign mode_field = ctrl_reg[`CTRL_XOVER_HI:`CTRL_XOVER_LO];

    always_comb begin
        ctrl_next = ctrl_reg;
        xmode_next = xmode_reg;
        if (wr_ctrl) begin
            ctrl_next = mgmt_req.wdata & `CTRL_WRITE_MASK;
        end
        // Written mode stays dormant until the next soft reset, so a
        // half-written setup never switches the wiring mid-link
        if (soft_reset) begin
            case (mode_field)
                `XOVER_CROSSED: xmode_next = XMODE_CROSSED;
                `XOVER_STRAIGHT: xmode_next = XMODE_STRAIGHT;
                // Reserved code falls back to automatic
                default: xmode_next = XMODE_AUTO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= `CTRL_RESET;
            xmode_reg <= XMODE_AUTO;
        end else begin
            ctrl_reg <= ctrl_next;
            xmode_reg <= xmode_next;
        end
    end

    // ======================================================================
    // Resolution and crossover state
    // Crossover is reported whatever the resolution state; software
    // has to qualify it with the resolved flag itself
    logic resolved;
    logic crossed;
    logic forced;

    always_comb begin
        forced = ~line_state.an_enabled;
        resolved = line_state.an_complete | forced;
        case (xmode_reg)
            XMODE_CROSSED: crossed = 1'b1;
            XMODE_STRAIGHT: crossed = 1'b0;
            default: crossed = line_state.mdix_detect;
        endcase
    end

    // ======================================================================
    // Page-received latch, cleared by a status read
    // A page arriving in the reading cycle stays latched for the next read
    logic [0:0] page_flag;

    sticky_flags #(
        .WIDTH(1)
    ) page_latch (
        .mclk(mclk),
        .srst(srst),
        .set_vec(line_pulse.page_rx),
        .clear(rd_status),
        .flags(page_flag)
    );

    // ======================================================================
    // Link status word
    logic [15:0] status_word;

    always_comb begin
        status_word = `WORD_ZERO;
        status_word[`ST_SPEED_HI:`ST_SPEED_LO] = line_state.speed;
        status_word[`ST_DUPLEX] = line_state.full_duplex;
        status_word[`ST_PAGE] = page_flag[0];
        status_word[`ST_RESOLVED] = resolved;
        status_word[`ST_LINK] = line_state.link_up;
        status_word[`ST_XOVER] = crossed;
        status_word[`ST_DOWNGRADE] = line_state.downgrade;
        // Pause results are informational; nothing here consumes them
        status_word[`ST_TX_PAUSE] = line_state.tx_pause_res
            & line_state.an_enabled;
        status_word[`ST_RX_PAUSE] = line_state.rx_pause_res
            & line_state.an_enabled & resolved;
        status_word[`ST_POLARITY] = line_state.polarity_rev;
        status_word[`ST_JABBER] = line_state.jabber;
    end

    // ======================================================================
    // Previous line state, for change detection
    logic [1:0] speed_prev_reg;
    logic duplex_prev_reg;
    logic link_prev_reg;
    logic pol_prev_reg;
    logic babble_prev_reg;
    logic dgrade_prev_reg;
    logic [1:0] speed_prev_next;
    logic duplex_prev_next;
    logic link_prev_next;
    logic pol_prev_next;
    logic babble_prev_next;
    logic dgrade_prev_next;

    always_comb begin
        speed_prev_next = line_state.speed;
        duplex_prev_next = line_state.full_duplex;
        link_prev_next = line_state.link_up;
        pol_prev_next = line_state.polarity_rev;
        babble_prev_next = line_state.jabber;
        dgrade_prev_next = line_state.downgrade;
    end

    // Reset values match the reset state of the line, so leaving reset
    // on a quiet line raises no spurious change event
    always_ff @(posedge mclk) begin
        if (srst) begin
            speed_prev_reg <= 2'h0;
            duplex_prev_reg <= 1'b0;
            link_prev_reg <= 1'b0;
            pol_prev_reg <= 1'b0;
            babble_prev_reg <= 1'b0;
            dgrade_prev_reg <= 1'b0;
        end else begin
            speed_prev_reg <= speed_prev_next;
            duplex_prev_reg <= duplex_prev_next;
            link_prev_reg <= link_prev_next;
            pol_prev_reg <= pol_prev_next;
            babble_prev_reg <= babble_prev_next;
            dgrade_prev_reg <= dgrade_prev_next;
        end
    end

    // ======================================================================
    // Event vector, laid out as the enable register
    logic [15:0] event_set;

    always_comb begin
        event_set = `WORD_ZERO;
        event_set[`EV_NEG_ERROR] = line_pulse.neg_error;
        event_set[`EV_RATE] = line_state.speed != speed_prev_reg;
        event_set[`EV_DUPLEX] = line_state.full_duplex ^ duplex_prev_reg;
        event_set[`EV_PAGE] = line_pulse.page_rx;
        event_set[`EV_LINK_FAIL] = link_prev_reg & ~line_state.link_up;
        event_set[`EV_LINK_UP] = ~link_prev_reg & line_state.link_up;
        event_set[`EV_WAKE] = line_pulse.wake_frame;
        event_set[`EV_DOWNGRADE] = line_state.downgrade & ~dgrade_prev_reg;
        event_set[`EV_POLARITY] = line_state.polarity_rev ^ pol_prev_reg;
        event_set[`EV_BABBLE] = line_state.jabber & ~babble_prev_reg;
    end

    // Every event is recorded whatever its enable; the enable only
    // decides whether it reaches the pending output
    logic [15:0] event_flags;

    sticky_flags #(
        .WIDTH(16)
    ) event_latch (
        .mclk(mclk),
        .srst(srst),
        .set_vec(event_set),
        .clear(rd_events),
        .flags(event_flags)
    );

    // ======================================================================
    // Event enable register
    logic [15:0] enable_reg;
    logic [15:0] enable_next;

    always_comb begin
        enable_next = enable_reg;
        if (wr_enable) begin
            // Reserved positions never store a one
            enable_next = mgmt_req.wdata & `EVENT_ENABLE_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            enable_reg <= `EVENT_ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // ======================================================================
    // Gating of recorded events onto the pending output
    logic [15:0] gated;

    always_comb begin
        gated = `WORD_ZERO;
        gated[`EV_NEG_ERROR] = event_flags[`EV_NEG_ERROR]
            & enable_reg[`EV_NEG_ERROR];
        gated[`EV_RATE] = event_flags[`EV_RATE]
            & enable_reg[`EV_RATE];
        gated[`EV_DUPLEX] = event_flags[`EV_DUPLEX]
            & enable_reg[`EV_DUPLEX];
        gated[`EV_PAGE] = event_flags[`EV_PAGE]
            & enable_reg[`EV_PAGE];
        gated[`EV_LINK_FAIL] = event_flags[`EV_LINK_FAIL]
            & enable_reg[`EV_LINK_FAIL];
        gated[`EV_LINK_UP] = event_flags[`EV_LINK_UP]
            & enable_reg[`EV_LINK_UP];
        gated[`EV_WAKE] = event_flags[`EV_WAKE]
            & enable_reg[`EV_WAKE];
        gated[`EV_DOWNGRADE] = event_flags[`EV_DOWNGRADE]
            & enable_reg[`EV_DOWNGRADE];
        gated[`EV_POLARITY] = event_flags[`EV_POLARITY]
            & enable_reg[`EV_POLARITY];
        gated[`EV_BABBLE] = event_flags[`EV_BABBLE]
            & enable_reg[`EV_BABBLE];
    end

    // ======================================================================
    // Read data and registered outputs
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic pending_reg;
    logic pending_next;
    logic mdix_reg;
    logic mdix_next;

    // Read data holds until the next read, so a slow host loses nothing
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = mgmt_req.rd;
        if (mgmt_req.rd) begin
            // Unmapped addresses answer with zero
            rdata_next = `WORD_ZERO;
            if (rd_ctrl) begin
                rdata_next = ctrl_reg;
            end else if (rd_status) begin
                rdata_next = status_word;
            end else if (rd_enable) begin
                rdata_next = enable_reg;
            end else if (rd_events) begin
                rdata_next = event_flags;
            end
        end
        pending_next = |gated;
        mdix_next = crossed;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= `WORD_ZERO;
            rvalid_reg <= 1'b0;
            pending_reg <= 1'b0;
            mdix_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            pending_reg <= pending_next;
            mdix_reg <= mdix_next;
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_rvalid = rvalid_reg;
    assign event_pending = pending_reg;
    assign mdix_select = mdix_reg;

endmodule : phy_status_regs

`default_nettype wire

// ===== pkg/phy_regs_params.svh
`ifndef PHY_REGS_PARAMS_SVH
`define PHY_REGS_PARAMS_SVH

// ==========================================================================
// Register addresses on the management port
`define ADDR_PHY_CTRL 5'h10
`define ADDR_LINK_STATUS 5'h11
`define ADDR_EVENT_ENABLE 5'h12
`define ADDR_EVENT_STATUS 5'h13

// ==========================================================================
// Link status register fields
`define ST_SPEED_HI 15
`define ST_SPEED_LO 14
`define ST_DUPLEX 13
`define ST_PAGE 12
`define ST_RESOLVED 11
`define ST_LINK 10
`define ST_XOVER 6
`define ST_DOWNGRADE 5
`define ST_TX_PAUSE 3
`define ST_RX_PAUSE 2
`define ST_POLARITY 1
`define ST_JABBER 0

// ==========================================================================
// Event enable and event status layout (shared)
`define EV_NEG_ERROR 15
`define EV_RATE 14
`define EV_DUPLEX 13
`define EV_PAGE 12
`define EV_LINK_FAIL 11
`define EV_LINK_UP 10
`define EV_WAKE 6
`define EV_DOWNGRADE 5
`define EV_POLARITY 1
`define EV_BABBLE 0
`define EVENT_ENABLE_MASK 16'hFC63
`define EVENT_ENABLE_RESET 16'h0000

// ==========================================================================
// Control register: crossover mode field and writable bits
`define CTRL_XOVER_HI 6
`define CTRL_XOVER_LO 5
`define CTRL_WRITE_MASK 16'h007F
`define CTRL_RESET 16'h0062
`define XOVER_AUTO 2'h3
`define XOVER_CROSSED 2'h1
`define XOVER_STRAIGHT 2'h0

`define WORD_ZERO 16'h0000

`endif

// ===== pkg/phy_regs_pkg.sv
package phy_regs_pkg;

    // Resolved line state, driven by the PHY core on mclk
    typedef struct packed {
        logic [1:0] speed;
        logic full_duplex;
        logic link_up;
        logic an_enabled;
        logic an_complete;
        logic mdix_detect;
        logic tx_pause_res;
        logic rx_pause_res;
        logic polarity_rev;
        logic jabber;
        logic downgrade;
    } phy_state_t;

    // One-cycle event pulses from the PHY core
    typedef struct packed {
        logic page_rx;
        logic neg_error;
        logic wake_frame;
    } phy_pulse_t;

    // Management request, one cycle per access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef enum logic [1:0] {
        XMODE_STRAIGHT,
        XMODE_CROSSED,
        XMODE_AUTO
    } xover_sel_t;

endpackage : phy_regs_pkg

// ===== hw/sticky_flags.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Sticky flags: set by hardware, cleared as a group by a read.
// A set in the clearing cycle survives so no event is lost.
module sticky_flags #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] set_vec,
    input wire logic clear,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    always_comb begin
        if (clear) begin
            flags_next = set_vec;
        end else begin
            flags_next = flags_reg | set_vec;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule : sticky_flags

`default_nettype wire

// ===== test/phy_status_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "phy_regs_params.svh"

module phy_status_regs_chk
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic soft_reset,
    input wire phy_state_t line_state,
    input wire phy_pulse_t line_pulse,
    input wire mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic event_pending,
    input wire logic mdix_select
);
    // ==========
    // Shadow of the written crossover mode, so reloads can be predicted
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic rd_st;
    logic rd_en;
    logic wr_en;
    assign rd_st = mgmt_req.rd && mgmt_req.addr == `ADDR_LINK_STATUS;
    assign rd_en = mgmt_req.rd && mgmt_req.addr == `ADDR_EVENT_ENABLE;
    assign wr_en = mgmt_req.wr && mgmt_req.addr == `ADDR_EVENT_ENABLE;
    always_comb begin
        mode_next = mode_reg;
        if (srst) begin
            mode_next = 2'h3;
        end else if (mgmt_req.wr && mgmt_req.addr == `ADDR_PHY_CTRL) begin
            mode_next = mgmt_req.wdata[6:5];
        end
    end
    always_ff @(posedge mclk) begin
        mode_reg <= mode_next;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // ==========
    // Status fields other than the page bit are only compared when the line was quiet around the read
    sequence s_calm_read;
        $stable(line_state) ##1 (rd_st && $stable(line_state));
    endsequence
    sequence s_en_write_read;
        wr_en ##1 !wr_en ##1 (rd_en && !mgmt_req.wr);
    endsequence

    property p_read_answer;
        mgmt_req.rd |=> mgmt_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");
    property p_no_spurious;
        !mgmt_req.rd |=> !mgmt_rvalid;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without read");
    property p_line_fields;
        s_calm_read |=> mgmt_rdata[15:13] == $past({line_state.speed,
            line_state.full_duplex}) && mgmt_rdata[10] == $past(line_state.link_up);
    endproperty
    a_line_fields: assert property (p_line_fields)
        else $error("speed, duplex or link field wrong");
    property p_resolved;
        s_calm_read |=> mgmt_rdata[11] ==
            $past(line_state.an_complete || !line_state.an_enabled);
    endproperty
    a_resolved: assert property (p_resolved)
        else $error("resolution flag wrong");
    property p_pause;
        s_calm_read |=> mgmt_rdata[3:2] == $past({line_state.tx_pause_res
            && line_state.an_enabled, line_state.rx_pause_res
            && line_state.an_enabled && line_state.an_complete});
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause resolution wrong");
    property p_flags;
        s_calm_read |=> mgmt_rdata[1:0] == $past({line_state.polarity_rev,
            line_state.jabber}) && mgmt_rdata[5] == $past(line_state.downgrade)
            && mgmt_rdata[9:7] == 3'h0 && !mgmt_rdata[4];
    endproperty
    a_flags: assert property (p_flags)
        else $error("polarity, jabber, downgrade or reserved bit wrong");
    property p_page_held;
        line_pulse.page_rx ##1 !rd_st ##1 rd_st |=> mgmt_rdata[12];
    endproperty
    a_page_held: assert property (p_page_held)
        else $error("page flag lost");
    property p_page_clear;
        (rd_st && !line_pulse.page_rx) ##1 rd_st |=> !mgmt_rdata[12];
    endproperty
    a_page_clear: assert property (p_page_clear)
        else $error("page flag not cleared by read");
    property p_en_readback;
        s_en_write_read |=> mgmt_rdata ==
            ($past(mgmt_req.wdata, 3) & `EVENT_ENABLE_MASK);
    endproperty
    a_en_readback: assert property (p_en_readback)
        else $error("enable register readback wrong");
    property p_pending_off;
        (wr_en && (mgmt_req.wdata & `EVENT_ENABLE_MASK) == `WORD_ZERO)
            ##1 !wr_en |=> !event_pending;
    endproperty
    a_pending_off: assert property (p_pending_off)
        else $error("event pending with all enables clear");
    property p_xover;
        (soft_reset && !mode_reg[1]) ##1 !soft_reset |=>
            mdix_select == $past(mode_reg[0], 2);
    endproperty
    a_xover: assert property (p_xover)
        else $error("manual crossover not applied");
endmodule : phy_status_regs_chk

bind phy_status_regs phy_status_regs_chk phy_status_regs_chk_inst (
    .mclk, .srst, .soft_reset, .line_state, .line_pulse, .mgmt_req,
    .mgmt_rdata, .mgmt_rvalid, .event_pending, .mdix_select
);

`default_nettype wire

// ===== test/mgmt_host.sv
`timescale 1ns/100ps
`default_nettype none

// ==========
// Management host: one request per cycle, fields scrambled when idle
module mgmt_host
    import phy_regs_pkg::*;
(
    input wire logic mclk,
    output var mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    initial mgmt_req = '0;

    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        mgmt_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        mgmt_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : write

    // n = 2 holds the strobe for two cycles: back-to-back reads
    task automatic read(input logic [4:0] a, input int n,
        output logic [15:0] d0, output logic [15:0] d1, output logic ok);
        int got;
        got = 0;
        d0 = 16'hxxxx;
        d1 = 16'hxxxx;
        @(posedge mclk);
        mgmt_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        for (int i = 0; i < n + 3 && got < n; i++) begin
            @(posedge mclk);
            if (i == n - 1) begin
                mgmt_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
            end
            if (i > 0 && mgmt_rvalid === 1'b1) begin
                if (got == 0) d0 = mgmt_rdata;
                else d1 = mgmt_rdata;
                got++;
            end
        end
        ok = (got == n);
    endtask : read
endmodule : mgmt_host

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "phy_regs_params.svh"

module testbench
    import phy_regs_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic soft_reset = 1'b0;
    phy_state_t ls = '0;
    phy_pulse_t lp = '0;
    mgmt_req_t mgmt_req;
    logic [15:0] mgmt_rdata, d0, d1, wv;
    logic mgmt_rvalid, event_pending, mdix_select, ok;
    logic [1:0] act;
    int num_errors = 0, samples_checked = 0, seed = 77;
    int ev_bits[10] = '{15, 14, 13, 12, 11, 10, 6, 5, 1, 0};
    logic [1:0] modes[4] = '{2'h1, 2'h0, 2'h2, 2'h3};

    always #25 mclk = ~mclk;

    phy_status_regs phy_status_regs_inst (.mclk(mclk), .srst(srst),
        .soft_reset(soft_reset), .line_state(ls), .line_pulse(lp),
        .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .event_pending(event_pending),
        .mdix_select(mdix_select));
    mgmt_host mgmt_host_inst (.mclk(mclk), .mgmt_req(mgmt_req),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    // ==========
    // Expected status word for a given line state, page flag and mode
    function automatic logic [15:0] exp_status(input phy_state_t s,
        input logic pg, input logic [1:0] m);
        logic [15:0] r;
        r = '0;
        r[15:14] = s.speed;
        r[13] = s.full_duplex;
        r[12] = pg;
        r[11] = s.an_complete | ~s.an_enabled;
        r[10] = s.link_up;
        r[6] = (m == 2'h1) ? 1'b1 : (m == 2'h0) ? 1'b0 : s.mdix_detect;
        r[5] = s.downgrade;
        r[3] = s.tx_pause_res & s.an_enabled;
        r[2] = s.rx_pause_res & s.an_enabled & r[11];
        r[1] = s.polarity_rev;
        r[0] = s.jabber;
        return r;
    endfunction : exp_status

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check16

    task automatic check1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check1

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic rd(input logic [4:0] a, input int n);
        mgmt_host_inst.read(a, n, d0, d1, ok);
        if (!ok) begin
            num_errors++;
            $display("Error at %0t: read not answered", $time);
            end_of_test;
        end
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    // Sets the quiet state before an event (pre) or makes the event
    task automatic poke(input int b, input logic pre);
        @(posedge mclk);
        case (b)
            `EV_NEG_ERROR: lp.neg_error <= !pre;
            `EV_RATE: ls.speed <= {1'b0, !pre};
            `EV_DUPLEX: ls.full_duplex <= !pre;
            `EV_PAGE: lp.page_rx <= !pre;
            `EV_LINK_FAIL: ls.link_up <= pre;
            `EV_LINK_UP: ls.link_up <= !pre;
            `EV_WAKE: lp.wake_frame <= !pre;
            `EV_DOWNGRADE: ls.downgrade <= !pre;
            `EV_POLARITY: ls.polarity_rev <= !pre;
            default: ls.jabber <= !pre;
        endcase
        @(posedge mclk);
        lp <= '0;
    endtask : poke

    initial begin
        idle(2);
        srst <= 1'b0;
        rd(`ADDR_EVENT_ENABLE, 1);
        check16(d0, `EVENT_ENABLE_RESET);
        rd(`ADDR_PHY_CTRL, 1);
        check16(d0, `CTRL_RESET);
        rd(5'h1a, 1);
        check16(d0, `WORD_ZERO);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            ls <= 12'($random(seed));
            idle(2);
            rd(`ADDR_LINK_STATUS, 1);
            check16(d0, exp_status(ls, 1'b0, 2'h3));
            wv = (i == 0) ? 16'h039c : 16'($random(seed));
            mgmt_host_inst.write(`ADDR_EVENT_ENABLE, wv);
            rd(`ADDR_EVENT_ENABLE, 1);
            check16(d0, wv & `EVENT_ENABLE_MASK);
        end
        poke(`EV_PAGE, 1'b0);
        rd(`ADDR_LINK_STATUS, 2);
        check16(d0, exp_status(ls, 1'b1, 2'h3));
        check16(d1, exp_status(ls, 1'b0, 2'h3));
        foreach (ev_bits[k]) begin
            poke(ev_bits[k], 1'b1);
            mgmt_host_inst.write(`ADDR_EVENT_ENABLE, 16'h0001 << ev_bits[k]);
            rd(`ADDR_EVENT_STATUS, 1);
            idle(3);
            #1 check1(event_pending, 1'b0);
            poke(ev_bits[k], 1'b0);
            idle(3);
            #1 check1(event_pending, 1'b1);
            mgmt_host_inst.write(`ADDR_EVENT_ENABLE, `WORD_ZERO);
            idle(2);
            #1 check1(event_pending, 1'b0);
            rd(`ADDR_EVENT_STATUS, 1);
            check16(d0, 16'h0001 << ev_bits[k]);
        end
        act = 2'h3;
        foreach (modes[k]) begin
            @(posedge mclk);
            ls.mdix_detect <= ~modes[k][0];
            mgmt_host_inst.write(`ADDR_PHY_CTRL, {9'h000, modes[k], 5'h02});
            idle(2);
            #1 check1(mdix_select, act[1] ? ~modes[k][0] : act[0]);
            @(posedge mclk);
            soft_reset <= 1'b1;
            @(posedge mclk);
            soft_reset <= 1'b0;
            act = modes[k];
            idle(3);
            #1 check1(mdix_select, act[1] ? ~act[0] : act[0]);
            rd(`ADDR_LINK_STATUS, 1);
            // The page event of the event loop is still latched at first
            check16(d0, exp_status(ls, k == 0, act));
        end
        end_of_test;
    end
endmodule : testbench

`default_nettype wire
